// [rtl/host_port.v]
`timescale 1ns/1ps
`include "host_port_consts.vh"
// =====================================================================
// host port strobe and ready logic
// Notes on behaviour
// [R1] strobe low when selected and strobes differ
// [R2] ready output held low while deselected
// [R3] busy shown on select while finishing prior op
// [R4] first-half data read fetches word, busy until loaded
// [R5] busy after second-half data write or auto read
// [R6] control and address accesses leave ready alone
// [R7] host holds strobe until ready goes low
// [R8] read data valid before ready falls
// [R9] selects sampled at strobe fall, held for access
module host_port #(
    parameter AW = 6
) (
    input wire REF_CLK,
    input wire ARST_N,
    input wire PORT_SELECT_N,
    input wire DATA_STROBE_ONE_N,
    input wire DATA_STROBE_TWO_N,
    input wire [1:0] ACCESS_TYPE_SELECT,
    input wire READ_WRITE_SELECT,
    input wire HALFWORD_ORDER_SELECT,
    input wire [15:0] HOST_DATA_BUS_IN,
    output reg [15:0] HOST_DATA_BUS_OUT,
    output wire HOST_DATA_BUS_OE,
    output wire PORT_BUSY_INDICATOR,
    output wire [31:0] PORT_CONTROL_REGISTER
);
    // =================================================================
    // strobe combine and edge detect
    wire combined_access_strobe; // active low
    assign combined_access_strobe = ~(DATA_STROBE_ONE_N ^ DATA_STROBE_TWO_N) | PORT_SELECT_N; // [R1]
    reg strobe_d_r; // strobe one cycle ago
    wire strobe_fall;
    wire strobe_rise;
    assign strobe_fall = strobe_d_r & ~combined_access_strobe;
    assign strobe_rise = ~strobe_d_r & combined_access_strobe;

    // =================================================================
    // state machine
    localparam ST_IDLE = 2'h0; // nothing pending
    localparam ST_FETCH = 2'h1; // read fetch in flight
    localparam ST_ACTIVE = 2'h2; // strobe low, data stable
    localparam ST_FINISH = 2'h3; // completing write or auto read
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] acc_type_r; // sampled access type
    reg rnw_r; // sampled read/write
    reg half_r; // sampled half-word select, 1 = second
    reg [31:0] data_latch_register;
    reg [31:0] address_pointer_register;
    reg [31:0] port_control_register;
    reg [1:0] fetch_cnt_r; // memory read latency counter
    reg busy_r; // internal busy level
    wire is_data;
    wire [1:0] acc_now;
    wire [31:0] mem_rd;
    reg mem_we;
    assign acc_now = ACCESS_TYPE_SELECT;
    assign is_data = (acc_type_r == `ACC_DATA_AUTO) | (acc_type_r == `ACC_DATA_FIXED);

    // memory behind the auxiliary channel
    word_store #(.AW(AW), .DW(32)) u_store (
        .clk(REF_CLK),
        .wr_en(mem_we),
        .addr(address_pointer_register[AW+1:2]),
        .wr_data(data_latch_register),
        .rd_data(mem_rd)
    );

    // ready is only driven while selected; low otherwise
    assign PORT_BUSY_INDICATOR = ~PORT_SELECT_N & busy_r; // [R2] [R3]
    // drive data bus during a read while strobe is low
    assign HOST_DATA_BUS_OE = rnw_r & (state_r == ST_ACTIVE) & ~combined_access_strobe;
    assign PORT_CONTROL_REGISTER = port_control_register;

    // =================================================================
    // next state
    always @*
    begin
        state_nxt = state_r;
        mem_we = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (strobe_fall)
                begin
                    // a first-half data read starts a fetch
                    if (READ_WRITE_SELECT & ~HALFWORD_ORDER_SELECT &&
                        (acc_now == `ACC_DATA_AUTO || acc_now == `ACC_DATA_FIXED))
                    begin
                        state_nxt = ST_FETCH; // [R4]
                    end
                    else
                    begin
                        state_nxt = ST_ACTIVE; // [R6]
                    end
                end
            end
            ST_FETCH:
            begin
                if (fetch_cnt_r == 2'h2)
                begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_ACTIVE:
            begin
                if (strobe_rise)
                begin
                    // only a second half data write or auto read needs finishing
                    if (half_r && ((is_data && !rnw_r) || acc_type_r == `ACC_DATA_AUTO))
                    begin
                        state_nxt = ST_FINISH; // [R5]
                    end
                    else
                    begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_FINISH:
            begin
                mem_we = ~rnw_r;
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // =================================================================
    // registers
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            strobe_d_r <= 1'b1;
            state_r <= ST_IDLE;
            acc_type_r <= 2'h0;
            rnw_r <= 1'b0;
            half_r <= 1'b0;
            fetch_cnt_r <= 2'h0;
            busy_r <= 1'b0;
            data_latch_register <= `DATA_LATCH_RST;
            address_pointer_register <= `ADDR_PTR_RST;
            port_control_register <= 32'h00000000;
            HOST_DATA_BUS_OUT <= 16'h0000;
        end
        else
        begin
            strobe_d_r <= combined_access_strobe;
            state_r <= state_nxt;
            // sample selects at strobe fall and keep them
            if (strobe_fall && state_r == ST_IDLE)
            begin
                acc_type_r <= acc_now; // [R9]
                rnw_r <= READ_WRITE_SELECT; // [R9]
                half_r <= HALFWORD_ORDER_SELECT; // [R9]
            end
            // busy high while fetching or finishing; a fetch keeps busy one extra
            // cycle so the read data are already on the bus when ready falls
            busy_r <= (state_nxt == ST_FETCH) | (state_nxt == ST_FINISH) |
                (state_r == ST_FETCH); // [R4] [R5] [R8]
            fetch_cnt_r <= (state_r == ST_FETCH) ? fetch_cnt_r + 2'h1 : 2'h0;
            // load latch from memory when fetch completes
            if (state_r == ST_FETCH && fetch_cnt_r == 2'h2)
            begin
                data_latch_register <= mem_rd; // [R4]
                // a fetch is always a first half, so the low half goes out now
                HOST_DATA_BUS_OUT <= mem_rd[15:0]; // [R8]
            end
            // present read data a cycle before ready may fall
            if (state_r == ST_ACTIVE && rnw_r)
            begin
                case (acc_type_r)
                    `ACC_CONTROL: HOST_DATA_BUS_OUT <= half_r ? port_control_register[31:16]
                        : port_control_register[15:0];
                    `ACC_ADDRESS: HOST_DATA_BUS_OUT <= half_r ? address_pointer_register[31:16]
                        : address_pointer_register[15:0];
                    default: HOST_DATA_BUS_OUT <= half_r ? data_latch_register[31:16]
                        : data_latch_register[15:0]; // [R8]
                endcase
            end
            // writes take host data while the strobe is held low; the last cycle
            // before the rise wins, since the host may drop its data with the strobe
            if (state_r == ST_ACTIVE && !combined_access_strobe && !rnw_r)
            begin
                case (acc_type_r)
                    `ACC_CONTROL:
                    begin
                        if (half_r)
                            port_control_register[31:16] <= HOST_DATA_BUS_IN;
                        else
                            port_control_register[15:0] <= HOST_DATA_BUS_IN;
                    end
                    `ACC_ADDRESS:
                    begin
                        if (half_r)
                            address_pointer_register[31:16] <= HOST_DATA_BUS_IN;
                        else
                            address_pointer_register[15:0] <= HOST_DATA_BUS_IN;
                    end
                    default:
                    begin
                        if (half_r)
                            data_latch_register[31:16] <= HOST_DATA_BUS_IN;
                        else
                            data_latch_register[15:0] <= HOST_DATA_BUS_IN;
                    end
                endcase
            end
            // auto increment after the operation completes
            if (state_r == ST_FINISH && acc_type_r == `ACC_DATA_AUTO)
            begin
                address_pointer_register <= address_pointer_register + `ADDR_STEP;
            end
        end
    end
endmodule // host_port

// [rtl/host_port_consts.vh]
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// access type codes carried on the access type select pins
`define ACC_CONTROL 2'h0
`define ACC_DATA_AUTO 2'h1
`define ACC_ADDRESS 2'h2
`define ACC_DATA_FIXED 2'h3
// reset value of the data latch
`define DATA_LATCH_RST 32'h00000000
// reset value of the address pointer
`define ADDR_PTR_RST 32'h00000000
// address step for auto increment, one word
`define ADDR_STEP 32'h00000004
`endif

// [rtl/word_store.v]
`timescale 1ns/1ps
// =====================================================================
// small word memory standing in for the memory behind the aux channel
module word_store #(
    parameter AW = 6,
    parameter DW = 32
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wr_data,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1]; // storage, no reset
    // registered read, one cycle latency
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // word_store

// [testbench/host_port_properties.sv]
`timescale 1ns/1ps
`include "host_port_consts.vh"
// ============================================
// pin-level checker of the host port handshake
module host_port_properties (
    input wire REF_CLK,
    input wire ARST_N,
    input wire PORT_SELECT_N,
    input wire DATA_STROBE_ONE_N,
    input wire DATA_STROBE_TWO_N,
    input wire [1:0] ACCESS_TYPE_SELECT,
    input wire READ_WRITE_SELECT,
    input wire HALFWORD_ORDER_SELECT,
    input wire [15:0] HOST_DATA_BUS_OUT,
    input wire HOST_DATA_BUS_OE,
    input wire PORT_BUSY_INDICATOR
);
    wire stb = ~(DATA_STROBE_ONE_N ^ DATA_STROBE_TWO_N) | PORT_SELECT_N;
    wire busy = PORT_BUSY_INDICATOR;
    reg stb_r; // strobe one cycle back
    reg [3:0] cap_r; // type, rw, half held from strobe fall
    wire fall = stb_r & ~stb;
    // latch the selects at each strobe fall
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            {stb_r, cap_r} <= 5'h10;
        else
            {stb_r, cap_r} <= fall ? {stb, ACCESS_TYPE_SELECT, READ_WRITE_SELECT,
                HALFWORD_ORDER_SELECT} : {stb, cap_r};
    end
    // after-ops: data write, or auto read, second half
    wire slow = cap_r[2] & cap_r[0] & (~cap_r[1] | ~cap_r[3]);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    property p_desel; PORT_SELECT_N |-> !busy; endproperty
    a_desel: assert property (p_desel) else $error("busy while deselected");
    property p_fetch; fall && ACCESS_TYPE_SELECT[0] && READ_WRITE_SELECT
        && !HALFWORD_ORDER_SELECT && !busy |-> ##[1:2] busy ##[1:4] !busy; endproperty
    a_fetch: assert property (p_fetch) else $error("no fetch busy");
    property p_wdone; $rose(stb) && slow |-> ##[1:2] (busy || PORT_SELECT_N); endproperty
    a_wdone: assert property (p_wdone) else $error("no finish busy");
    property p_quiet; $rose(stb) && !cap_r[2] && !$past(busy) |-> !busy [*3]; endproperty
    a_quiet: assert property (p_quiet) else $error("busy after reg access");
    property p_noop; $rose(stb) && cap_r[1] && cap_r[3:2] == `ACC_DATA_FIXED
        |-> !busy [*2]; endproperty
    a_noop: assert property (p_noop) else $error("busy after plain read");
    property p_cause; $rose(busy) && stb |-> slow; endproperty
    a_cause: assert property (p_cause) else $error("busy without pending op");
    property p_rdvalid; busy && !stb && cap_r[1] ##1 !busy
        |-> $past(HOST_DATA_BUS_OE) && $stable(HOST_DATA_BUS_OUT)
        ##1 $stable(HOST_DATA_BUS_OUT); endproperty
    a_rdvalid: assert property (p_rdvalid) else $error("data late for ready");
    property p_oe; HOST_DATA_BUS_OE |-> !PORT_SELECT_N && READ_WRITE_SELECT; endproperty
    a_oe: assert property (p_oe) else $error("bus driven outside read");
    c_fetch: cover property (fall && READ_WRITE_SELECT && !HALFWORD_ORDER_SELECT);
    c_pend: cover property ($rose(busy) && stb);
    c_ctl: cover property ($rose(stb) && cap_r[3:2] == `ACC_CONTROL);
endmodule // host_port_properties
bind host_port host_port_properties u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .PORT_SELECT_N(PORT_SELECT_N), .DATA_STROBE_ONE_N(DATA_STROBE_ONE_N),
    .DATA_STROBE_TWO_N(DATA_STROBE_TWO_N), .ACCESS_TYPE_SELECT(ACCESS_TYPE_SELECT),
    .READ_WRITE_SELECT(READ_WRITE_SELECT), .HALFWORD_ORDER_SELECT(HALFWORD_ORDER_SELECT),
    .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT), .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
    .PORT_BUSY_INDICATOR(PORT_BUSY_INDICATOR));

// [testbench/host_model.sv]
`timescale 1ns/1ps
// ============================================
// external host: moves only at falling clock edges
module host_model (
    input wire clk,
    input wire busy,
    input wire [15:0] dout,
    output reg sel_n,
    output reg ds1_n,
    output reg ds2_n,
    output reg [1:0] typ,
    output reg rw,
    output reg half,
    output reg [15:0] din
);
    integer pre; // busy cycles seen after select fell
    integer n; // busy cycles seen during the strobe
    initial
        {sel_n, ds1_n, ds2_n, typ, rw, half, din} = {3'h7, 20'h00000};
    // one half-word access, bounded waits stand in for a bus timeout
    task acc(input [1:0] t, input r, input h, input [15:0] d, output [15:0] q);
        begin
            @(negedge clk);
            {typ, rw, half, din, sel_n} = {t, r, h, d, 1'b0};
            // look once just after select falls: a pending finish may last one cycle
            #5 pre = busy ? 1 : 0;
            @(negedge clk);
            while (busy && pre < 40)
            begin
                pre = pre + 1;
                @(negedge clk);
            end
            {ds1_n, ds2_n} = h ? 2'h2 : 2'h1;
            n = 0;
            repeat (3) @(negedge clk);
            while (busy && n < 40)
            begin
                n = n + 1;
                @(negedge clk);
            end
            q = dout;
            // released write lines show the inverse, not a stale value
            {ds1_n, ds2_n, sel_n, din} = {3'h7, ~d};
        end
    endtask
endmodule // host_model

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "host_port_consts.vh"
// ============================================
// bench: host model drives the port, tasks judge results
module tb;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    integer num_errors = 0;
    integer total_checks = 0;
    integer cyc = 0;
    wire sel_n, ds1_n, ds2_n, rw, half, oe, busy;
    wire [1:0] typ;
    wire [15:0] din, dout;
    wire [31:0] ctl;
    reg [15:0] q;
    reg [31:0] v;
    always #25 clk = ~clk;
    host_port #(.AW(6)) dut (.REF_CLK(clk), .ARST_N(arst_n), .PORT_SELECT_N(sel_n),
        .DATA_STROBE_ONE_N(ds1_n), .DATA_STROBE_TWO_N(ds2_n), .ACCESS_TYPE_SELECT(typ),
        .READ_WRITE_SELECT(rw), .HALFWORD_ORDER_SELECT(half), .HOST_DATA_BUS_IN(din),
        .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe), .PORT_BUSY_INDICATOR(busy),
        .PORT_CONTROL_REGISTER(ctl));
    host_model host (.clk(clk), .busy(busy), .dout(dout), .sel_n(sel_n), .ds1_n(ds1_n),
        .ds2_n(ds2_n), .typ(typ), .rw(rw), .half(half), .din(din));
    // ============================================
    // shared compare and transfer tasks
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("wrong value %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr32(input [1:0] t, input [31:0] w);
        begin
            host.acc(t, 1'b0, 1'b0, w[15:0], q);
            host.acc(t, 1'b0, 1'b1, w[31:16], q);
        end
    endtask
    // ============================================
    // scenarios
    task t_ctl;
        begin
            chk("ctl reset", 32'h0, ctl);
            wr32(`ACC_CONTROL, 32'ha5c30f69);
            chk("ctl", 32'ha5c30f69, ctl);
            chk("ctl busy", 32'h0, host.n);
            host.acc(`ACC_CONTROL, 1'b1, 1'b0, 16'h0000, q);
            chk("ctl pend", 32'h0, host.pre);
            chk("ctl lo", 32'h0f69, q);
        end
    endtask
    task t_fixed;
        begin
            wr32(`ACC_ADDRESS, 32'h8);
            wr32(`ACC_DATA_FIXED, 32'h1234abcd);
            wr32(`ACC_ADDRESS, 32'hc);
            chk("wr pend", 32'h0, host.pre);
            wr32(`ACC_DATA_FIXED, 32'h5a5a0ff0);
            wr32(`ACC_ADDRESS, 32'h8);
            host.acc(`ACC_DATA_FIXED, 1'b1, 1'b0, 16'h0000, q);
            chk("fetch busy", 32'h1, host.n > 0);
            chk("rd lo", 32'habcd, q);
            host.acc(`ACC_DATA_FIXED, 1'b1, 1'b1, 16'h0000, q);
            chk("rd hi busy", 32'h0, host.n);
            chk("rd hi", 32'h1234, q);
        end
    endtask
    task t_auto;
        begin
            host.acc(`ACC_DATA_AUTO, 1'b1, 1'b0, 16'h0000, v[15:0]);
            host.acc(`ACC_DATA_AUTO, 1'b1, 1'b1, 16'h0000, v[31:16]);
            chk("auto 0", 32'h1234abcd, v);
            host.acc(`ACC_DATA_AUTO, 1'b1, 1'b0, 16'h0000, v[15:0]);
            chk("auto pend", 32'h1, host.pre > 0);
            host.acc(`ACC_DATA_AUTO, 1'b1, 1'b1, 16'h0000, v[31:16]);
            chk("auto 1", 32'h5a5a0ff0, v);
            // auto-increment write: busy on the next select, pointer steps one word
            wr32(`ACC_ADDRESS, 32'h10);
            wr32(`ACC_DATA_AUTO, 32'h3c3cc3c3);
            host.acc(`ACC_ADDRESS, 1'b1, 1'b0, 16'h0000, q);
            chk("auto wr pend", 32'h1, host.pre > 0);
            chk("auto wr step", 32'h0014, q);
            wr32(`ACC_ADDRESS, 32'h10);
            host.acc(`ACC_DATA_FIXED, 1'b1, 1'b0, 16'h0000, v[15:0]);
            host.acc(`ACC_DATA_FIXED, 1'b1, 1'b1, 16'h0000, v[31:16]);
            chk("auto wr data", 32'h3c3cc3c3, v);
        end
    endtask
    task end_sim;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // hang guard, far above the roughly 160 cycles the run needs
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    initial
    begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        t_ctl;
        t_fixed;
        t_auto;
        end_sim;
    end
endmodule // tb
